// ### logic/timer_if.sv
// control and status bundle between the top module and one 16-bit timer
// unit; the top drives the settings, the unit answers with count and steps
`timescale 1ns/1ps
interface timer_if;
   logic        run;       // run bit
   logic        stop;      // idle stop in force
   logic        gate_en;   // gated accumulation
   logic        ext_sel;   // count external pin
   logic [1:0]  presc;     // prescale select
   logic        ext_rise;  // synchronised pin rising edge
   logic        gate_lvl;  // synchronised pin level
   logic        wide;      // part of joined pair, no own period
   logic        cascade;   // high half, stepped by carry
   logic        carry_in;  // carry from low half
   logic        clr;       // joined period match
   logic        wr;        // software count write
   logic [15:0] wdata;     // count write data
   logic [15:0] period;    // own period
   logic [15:0] count;     // current count
   logic        step;      // count advances this cycle
   logic        carry;     // step at top of range
   logic        match;     // own period match
   modport ctl  (output run, stop, gate_en, ext_sel, presc, ext_rise,
                 gate_lvl, wide, cascade, carry_in, clr, wr, wdata,
                 period, input count, step, carry, match);
   modport unit (input run, stop, gate_en, ext_sel, presc, ext_rise,
                 gate_lvl, wide, cascade, carry_in, clr, wr, wdata,
                 period, output count, step, carry, match);
endinterface

// ### logic/timer_pair_capture.sv
// timer pair (two 16-bit or one 32-bit) with input capture channel
// assumes an apb master on pclk; pins arrive asynchronously
//
// Functional notes
// - run bit starts and stops timer
// - idle stop halts timer in idle
// - gate accumulates internal clock, ignored external
// - prescale 1, 8, 64 or 256
// - join bit makes one 32-bit timer
// - clock source: pin rising edge or internal
// - joined: high control bits have no effect
// - unused bits read zero, reset zero
// - capture halts in idle when set
// - timebase select picks low or high count
// - interrupt every 1 to 4 captures
// - read-only overrun flag on capture overflow
// - buffer not empty status bit
// - captures held in four-entry fifo
// - mode 111 wake edge in sleep/idle
// - modes 101/100 every 16th/4th rise
// - modes 011/010 rising or falling edge
// - mode 001 both edges, every-capture interrupt
// - modes 000 and 110 channel off
// - high count is upper word when joined
// - joined match raises high timer interrupt
// - joined 32-bit count matches 32-bit period
`timescale 1ns/1ps
module timer_pair_capture #(
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic        pclk,         // 100 MHz clock
   input  wire logic        presetn,      // async reset, low
   input  wire logic        psel,         // apb select
   input  wire logic        penable,      // apb enable
   input  wire logic        pwrite,       // apb direction
   input  wire logic [7:0]  paddr,        // apb byte address
   input  wire logic [31:0] pwdata,       // apb write data
   output logic      [31:0] prdata,       // apb read data
   output logic             pready,       // apb ready
   output logic             pslverr,      // apb error
   input  wire logic        idle_mode,    // device in idle
   input  wire logic        sleep_mode,   // device in sleep
   input  wire logic        lo_ext_pin,   // low timer count pin
   input  wire logic        hi_ext_pin,   // high timer count pin
   input  wire logic        capture_input_pin, // capture pin
   output logic             low_irq,      // low timer match
   output logic             high_irq,     // high or joined match
   output logic             capture_irq,  // capture interrupt
   output logic             wake_irq      // wake edge
);
   localparam int PTR_W  = $clog2(FIFO_DEPTH);
   localparam int FILL_W = $clog2(FIFO_DEPTH + 1);
   localparam logic [FILL_W-1:0] FULL_N = FILL_W'(FIFO_DEPTH);

   timer_if lo ();
   timer_if hi ();

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: s1 feeds only s2

   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_p_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_p_q  <= '0;
      end
      else
      begin
         pin_s1_q <= {capture_input_pin, hi_ext_pin, lo_ext_pin};
         pin_s2_q <= pin_s1_q;
         pin_p_q  <= pin_s2_q;
      end
   end

   wire logic [2:0] rise = pin_s2_q & ~pin_p_q;
   wire logic [2:0] fall = ~pin_s2_q & pin_p_q;

   ////////////////////////////////////////////////////////////////////////
   // apb decode

   wire logic setup  = psel & ~penable;
   wire logic wr_acc = psel & penable & pready & pwrite;
   wire logic rd_set = setup & ~pwrite;

   wire logic hit_lo_ctl = paddr == tpc_pkg::OFF_LO_CTRL;
   wire logic hit_hi_ctl = paddr == tpc_pkg::OFF_HI_CTRL;
   wire logic hit_lo_cnt = paddr == tpc_pkg::OFF_LO_CNT;
   wire logic hit_hi_cnt = paddr == tpc_pkg::OFF_HI_CNT;
   wire logic hit_lo_per = paddr == tpc_pkg::OFF_LO_PER;
   wire logic hit_hi_per = paddr == tpc_pkg::OFF_HI_PER;
   wire logic hit_cap    = paddr == tpc_pkg::OFF_CAP_CTL;
   wire logic hit_buf    = paddr == tpc_pkg::OFF_CAP_BUF;
   wire logic mapped     = hit_lo_ctl | hit_hi_ctl | hit_lo_cnt |
                           hit_hi_cnt | hit_lo_per | hit_hi_per |
                           hit_cap | hit_buf;

   ////////////////////////////////////////////////////////////////////////
   // control registers

   logic [15:0] lo_ctrl_q;
   logic [15:0] hi_ctrl_q;
   logic [15:0] lo_per_q;
   logic [15:0] hi_per_q;
   logic [15:0] cap_ctrl_q;

   // only implemented bits are stored, so the rest read zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lo_ctrl_q  <= tpc_pkg::CTRL_RST;
         hi_ctrl_q  <= tpc_pkg::CTRL_RST;
         cap_ctrl_q <= tpc_pkg::CTRL_RST;
         lo_per_q   <= tpc_pkg::PER_RST;
         hi_per_q   <= tpc_pkg::PER_RST;
      end
      else if (wr_acc)
      begin
         if (hit_lo_ctl)
            lo_ctrl_q <= pwdata[15:0] & tpc_pkg::LO_MASK;
         if (hit_hi_ctl)
            hi_ctrl_q <= pwdata[15:0] & tpc_pkg::HI_MASK;
         if (hit_cap)
            cap_ctrl_q <= pwdata[15:0] & tpc_pkg::CAP_MASK;
         if (hit_lo_per)
            lo_per_q <= pwdata[15:0];
         if (hit_hi_per)
            hi_per_q <= pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timer pair

   wire logic        pair_join = lo_ctrl_q[tpc_pkg::JOIN_BIT];
   wire logic [31:0] cnt32 = {hi.count, lo.count};
   wire logic [31:0] per32 = {hi_per_q, lo_per_q};
   wire logic        clr32 = pair_join & lo.step & (cnt32 == per32);

   assign lo.run      = lo_ctrl_q[tpc_pkg::RUN_BIT];
   assign lo.stop     = lo_ctrl_q[tpc_pkg::IDLE_BIT] & idle_mode;
   assign lo.gate_en  = lo_ctrl_q[tpc_pkg::GATE_BIT];
   assign lo.ext_sel  = lo_ctrl_q[tpc_pkg::CS_BIT];
   assign lo.presc    = lo_ctrl_q[tpc_pkg::PS_HI:tpc_pkg::PS_LO];
   assign lo.ext_rise = rise[0];
   assign lo.gate_lvl = pin_s2_q[0];
   assign lo.wide     = pair_join;
   assign lo.cascade  = 1'b0;
   assign lo.carry_in = 1'b0;
   assign lo.clr      = clr32;
   assign lo.wr       = wr_acc & hit_lo_cnt;
   assign lo.wdata    = pwdata[15:0];
   assign lo.period   = lo_per_q;

   assign hi.run      = hi_ctrl_q[tpc_pkg::RUN_BIT];
   assign hi.stop     = hi_ctrl_q[tpc_pkg::IDLE_BIT] & idle_mode;
   assign hi.gate_en  = hi_ctrl_q[tpc_pkg::GATE_BIT];
   assign hi.ext_sel  = hi_ctrl_q[tpc_pkg::CS_BIT];
   assign hi.presc    = hi_ctrl_q[tpc_pkg::PS_HI:tpc_pkg::PS_LO];
   assign hi.ext_rise = rise[1];
   assign hi.gate_lvl = pin_s2_q[1];
   assign hi.wide     = pair_join;
   assign hi.cascade  = pair_join;
   assign hi.carry_in = lo.carry;
   assign hi.clr      = clr32;
   assign hi.wr       = wr_acc & hit_hi_cnt;
   assign hi.wdata    = pwdata[15:0];
   assign hi.period   = hi_per_q;

   timer_unit u_lo (
      .pclk    (pclk),
      .presetn (presetn),
      .t       (lo)
   );

   timer_unit u_hi (
      .pclk    (pclk),
      .presetn (presetn),
      .t       (hi)
   );

   ////////////////////////////////////////////////////////////////////////
   // capture channel

   logic [3:0]        edge_cnt_q;
   logic [1:0]        irq_cnt_q;
   logic              ovf_q;
   logic [15:0]       mem_q [FIFO_DEPTH];
   logic [PTR_W-1:0]  wp_q;
   logic [PTR_W-1:0]  rp_q;
   logic [FILL_W-1:0] fill_q;

   wire tpc_pkg::cap_mode_t mode =
      tpc_pkg::cap_mode_t'(cap_ctrl_q[tpc_pkg::MODE_HI:0]);
   wire logic [1:0] captures_per_irq = cap_ctrl_q[tpc_pkg::ICI_HI:tpc_pkg::ICI_LO];
   wire logic halt = cap_ctrl_q[tpc_pkg::IDLE_BIT] & idle_mode;
   wire logic live = ~halt & (mode != tpc_pkg::CM_OFF) &
                     (mode != tpc_pkg::CM_UNUSED) &
                     (mode != tpc_pkg::CM_WAKE);
   wire logic cap_edge =
      (mode == tpc_pkg::CM_BOTH) ? (rise[2] | fall[2]) :
      (mode == tpc_pkg::CM_FALL) ? fall[2] : rise[2];
   wire logic [3:0] edge_lim =
      (mode == tpc_pkg::CM_RISE16) ? tpc_pkg::RISE16_N :
      (mode == tpc_pkg::CM_RISE4)  ? tpc_pkg::RISE4_N  : '0;
   wire logic edge_hit  = edge_cnt_q >= edge_lim;
   wire logic cap_event = live & cap_edge & edge_hit;
   wire logic [15:0] cap_val =
      cap_ctrl_q[tpc_pkg::TB_BIT] ? lo.count : hi.count;
   wire logic full  = fill_q == FULL_N;
   wire logic bne   = fill_q != '0;
   wire logic push  = cap_event & ~full;
   wire logic ovf_set = cap_event & full;
   wire logic pop   = rd_set & hit_buf & bne;
   wire logic cap_wr = wr_acc & hit_cap;
   wire logic ovf_clr = cap_wr &
      (pwdata[tpc_pkg::MODE_HI:0] == tpc_pkg::CM_OFF);
   wire logic irq_hit = (mode == tpc_pkg::CM_BOTH) ||
                        (irq_cnt_q == captures_per_irq);

   // a mode write restarts the edge and interrupt counts
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         edge_cnt_q <= '0;
         irq_cnt_q  <= '0;
      end
      else if (cap_wr || !live)
      begin
         edge_cnt_q <= '0;
         irq_cnt_q  <= '0;
      end
      else
      begin
         if (cap_edge)
            edge_cnt_q <= edge_hit ? '0 : edge_cnt_q + 4'h1;
         if (cap_event)
            irq_cnt_q <= irq_hit ? '0 : irq_cnt_q + 2'h1;
      end
   end

   // set wins over the clear by turning the channel off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ovf_q <= 1'b0;
      else if (ovf_set)
         ovf_q <= 1'b1;
      else if (ovf_clr)
         ovf_q <= 1'b0;
   end

   // depth must be a power of two so the pointers wrap by themselves
   always_ff @(posedge pclk)
   begin
      if (push)
         mem_q[wp_q] <= cap_val;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wp_q   <= '0;
         rp_q   <= '0;
         fill_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
         if (push && !pop)
            fill_q <= fill_q + 1'b1;
         else if (pop && !push)
            fill_q <= fill_q - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux and registered outputs

   wire logic [15:0] cap_rd = cap_ctrl_q |
      ({15'h0, ovf_q} << tpc_pkg::OV_BIT) |
      ({15'h0, bne} << tpc_pkg::BNE_BIT);
   wire logic [15:0] rd16 =
      hit_lo_ctl ? lo_ctrl_q : hit_hi_ctl ? hi_ctrl_q :
      hit_lo_cnt ? lo.count  : hit_hi_cnt ? hi.count  :
      hit_lo_per ? lo_per_q  : hit_hi_per ? hi_per_q  :
      hit_cap    ? cap_rd    :
      (hit_buf && bne) ? mem_q[rp_q] : '0;

   // read data and pops are taken at setup, so access is one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata      <= '0;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         low_irq     <= 1'b0;
         high_irq    <= 1'b0;
         capture_irq <= 1'b0;
         wake_irq    <= 1'b0;
      end
      else
      begin
         pready      <= setup;
         pslverr     <= setup & ~mapped;
         prdata      <= rd_set ? {16'h0, rd16} : '0;
         low_irq     <= ~pair_join & lo.match;
         high_irq    <= pair_join ? clr32 : hi.match;
         capture_irq <= cap_event & irq_hit;
         wake_irq    <= (mode == tpc_pkg::CM_WAKE) &
                        (sleep_mode | idle_mode) & rise[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_run_stop;
      (!lo.run && !pair_join && !lo.wr && !lo.clr) |=> $stable(lo.count);
   endproperty
   a_run_stop: assert property (p_run_stop)
      else $error("low timer moved while stopped");

   property p_idle_stop;
      (lo.stop && !lo.wr && !lo.clr) |=> $stable(lo.count);
   endproperty
   a_idle_stop: assert property (p_idle_stop)
      else $error("low timer moved in idle stop");

   sequence s_quiet7;
      !lo.step [*7];
   endsequence
   property p_presc8;
      (lo.step && lo.presc == 2'h1 && lo.run && !lo.stop &&
       !lo.ext_sel && !lo.gate_en) |=> s_quiet7;
   endproperty
   a_presc8: assert property (p_presc8)
      else $error("prescale 1:8 stepped early");

   property p_join_match;
      clr32 |=> (cnt32 == '0) && high_irq && !low_irq;
   endproperty
   a_join_match: assert property (p_join_match)
      else $error("joined match did not clear and flag");

   property p_bne;
      (push && !pop) |=> bne;
   endproperty
   a_bne: assert property (p_bne)
      else $error("buffer not empty missing after capture");

   property p_overrun;
      (cap_event && full && !pop) |=> ovf_q && full;
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun not flagged or value stored");

   property p_pop_last;
      (pop && fill_q == 1 && !push) |=> !bne;
   endproperty
   a_pop_last: assert property (p_pop_last)
      else $error("buffer not empty after last read");

   property p_every_cap;
      (cap_event && captures_per_irq == 2'h0) |=> capture_irq;
   endproperty
   a_every_cap: assert property (p_every_cap)
      else $error("capture interrupt missing");

   property p_wake_only;
      (mode == tpc_pkg::CM_WAKE) |-> !push && !cap_event;
   endproperty
   a_wake_only: assert property (p_wake_only)
      else $error("wake mode stored a capture");

   property p_off;
      (mode == tpc_pkg::CM_OFF || mode == tpc_pkg::CM_UNUSED) |-> !push;
   endproperty
   a_off: assert property (p_off)
      else $error("disabled channel captured");

   property p_rsvd_zero;
      (pready && hit_lo_ctl && !pwrite) |-> (prdata[15:0] &
         ~tpc_pkg::LO_MASK) == '0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("unimplemented control bits read nonzero");
endmodule

// ### logic/timer_unit.sv
// one 16-bit timer with prescaler, gate and period match
// assumes pin signals already synchronised to pclk by the top module
`timescale 1ns/1ps
module timer_unit (
   input wire logic pclk,     // clock
   input wire logic presetn,  // async reset, low
   timer_if.unit    t         // settings and count
);
   logic [7:0]  pre_q;
   logic [15:0] cnt_q;

   wire logic       active   = t.run & ~t.stop;
   wire logic       tick_src = t.ext_sel ? t.ext_rise
                                         : (~t.gate_en | t.gate_lvl);
   wire logic       tick     = active & tick_src;
   wire logic [7:0] lim      =
      (t.presc == 2'h3) ? tpc_pkg::PS_LIM256 :
      (t.presc == 2'h2) ? tpc_pkg::PS_LIM64  :
      (t.presc == 2'h1) ? tpc_pkg::PS_LIM8   : tpc_pkg::PS_LIM1;
   wire logic       pre_hit  = pre_q >= lim;

   // the high half of a joined pair ignores its own settings
   assign t.step  = t.cascade ? t.carry_in : (tick & pre_hit);
   assign t.match = t.step & ~t.wide & (cnt_q == t.period);
   assign t.carry = t.step & (cnt_q == tpc_pkg::CNT_MAX);
   assign t.count = cnt_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre_q <= '0;
      else if (!active || t.cascade)
         pre_q <= '0;
      else if (tick)
         pre_q <= pre_hit ? '0 : pre_q + 8'h01;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= '0;
      else if (t.wr)
         cnt_q <= t.wdata;
      else if (t.clr || t.match)
         cnt_q <= '0;
      else if (t.step)
         cnt_q <= cnt_q + 16'h0001;
   end
endmodule

// ### logic/tpc_pkg.sv
// register map, field positions and mode codes of the timer pair with
// input capture; shared by the top module, the timer unit and the bench
package tpc_pkg;
   localparam logic [7:0]  OFF_LO_CTRL = 8'h00;
   localparam logic [7:0]  OFF_HI_CTRL = 8'h04;
   localparam logic [7:0]  OFF_LO_CNT  = 8'h08;
   localparam logic [7:0]  OFF_HI_CNT  = 8'h0c;
   localparam logic [7:0]  OFF_LO_PER  = 8'h10;
   localparam logic [7:0]  OFF_HI_PER  = 8'h14;
   localparam logic [7:0]  OFF_CAP_CTL = 8'h18;
   localparam logic [7:0]  OFF_CAP_BUF = 8'h1c;

   localparam logic [15:0] CTRL_RST    = 16'h0000;
   localparam logic [15:0] PER_RST     = 16'hffff;
   localparam logic [15:0] CNT_MAX     = 16'hffff;
   localparam logic [15:0] LO_MASK     = 16'ha07a;
   localparam logic [15:0] HI_MASK     = 16'ha072;
   localparam logic [15:0] CAP_MASK    = 16'h20e7;

   localparam int RUN_BIT  = 15;
   localparam int IDLE_BIT = 13;
   localparam int GATE_BIT = 6;
   localparam int PS_HI    = 5;
   localparam int PS_LO    = 4;
   localparam int JOIN_BIT = 3;
   localparam int CS_BIT   = 1;
   localparam int TB_BIT   = 7;
   localparam int ICI_HI   = 6;
   localparam int ICI_LO   = 5;
   localparam int OV_BIT   = 4;
   localparam int BNE_BIT  = 3;
   localparam int MODE_HI  = 2;

   localparam logic [7:0]  PS_LIM1   = 8'h00;
   localparam logic [7:0]  PS_LIM8   = 8'h07;
   localparam logic [7:0]  PS_LIM64  = 8'h3f;
   localparam logic [7:0]  PS_LIM256 = 8'hff;
   localparam logic [3:0]  RISE4_N   = 4'h3;
   localparam logic [3:0]  RISE16_N  = 4'hf;

   typedef enum logic [2:0] {
      CM_OFF    = 3'h0,
      CM_BOTH   = 3'h1,
      CM_FALL   = 3'h2,
      CM_RISE   = 3'h3,
      CM_RISE4  = 3'h4,
      CM_RISE16 = 3'h5,
      CM_UNUSED = 3'h6,
      CM_WAKE   = 3'h7
   } cap_mode_t;
endpackage

// ### tb/pin_model.sv
// far-side pins: capture input and the two timer count/gate pins
// assumes it is called just after a rising pclk edge
`timescale 1ns/1ps
module pin_model (
   input  wire logic pclk,    // bench clock
   output logic      cap_pin, // capture input
   output logic      lo_pin,  // low timer pin
   output logic      hi_pin   // high timer pin
);
   initial
   begin
      cap_pin = 1'b0;
      lo_pin  = 1'b0;
      hi_pin  = 1'b0;
   end

   task automatic drive(input int which, input logic v);
      case (which)
         0: cap_pin <= v;
         1: lo_pin <= v;
         default: hi_pin <= v;
      endcase
   endtask

   // three cycles each level so the 2-flop synchroniser never loses one
   task automatic pulses(input int which, input int n);
      repeat (n)
      begin
         drive(which, 1'b1);
         repeat (3) @(posedge pclk);
         drive(which, 1'b0);
         repeat (3) @(posedge pclk);
      end
   endtask
endmodule

// ### tb/tb_timer_pair_capture.sv
// self-checking bench for the timer pair with input capture
// assumes an apb slave with one wait-free access cycle
`timescale 1ns/1ps
module tb_timer_pair_capture;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, idle_mode = 1'b0, sleep_mode = 1'b0;
   logic        lo_pin, hi_pin, cap_pin;
   logic        low_irq, high_irq, capture_irq, wake_irq;
   logic [31:0] v;
   logic        e;
   int          checks = 0, n_mismatch = 0;
   int          n_low = 0, n_high = 0, n_cap = 0, n_wake = 0, b0, b1;

   always #5 pclk = ~pclk;

   timer_pair_capture u_timer_pair_capture (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
      .lo_ext_pin(lo_pin), .hi_ext_pin(hi_pin),
      .capture_input_pin(cap_pin), .low_irq(low_irq), .high_irq(high_irq),
      .capture_irq(capture_irq), .wake_irq(wake_irq));

   pin_model u_pin_model (.pclk(pclk), .cap_pin(cap_pin), .lo_pin(lo_pin),
      .hi_pin(hi_pin));

   // pulses are counted with nonblocking updates so snapshots never race
   always @(posedge pclk)
   begin
      if (low_irq === 1'b1) n_low <= n_low + 1;
      if (high_irq === 1'b1) n_high <= n_high + 1;
      if (capture_irq === 1'b1) n_cap <= n_cap + 1;
      if (wake_irq === 1'b1) n_wake <= n_wake + 1;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_mismatch++;
      v = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0000, d});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input string name);
      apb(1'b0, a, 32'h0);
      check(name, v, exp);
   endtask

   task automatic rd_rng(input logic [7:0] a, input int lo, hi);
      apb(1'b0, a, 32'h0);
      check("count range", {31'h0, (v >= lo && v <= hi)}, 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] t_ctl [14] = '{16'h0001, 16'h0061, 16'h0002, 16'h0003,
      16'h0004, 16'h0005, 16'h0000, 16'h0006, 16'h0023, 16'h0043,
      16'h0063, 16'h2003, 16'h0007, 16'h0007};
   int t_np [14]   = '{2, 2, 3, 3, 12, 32, 3, 3, 4, 3, 4, 2, 2, 2};
   int t_cap [14]  = '{4, 4, 3, 3, 3, 2, 0, 0, 2, 1, 1, 0, 0, 0};
   int t_env [14]  = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 0};

   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(tpc_pkg::OFF_LO_CTRL, 32'h0, "lo ctrl reset");
      rd_chk(tpc_pkg::OFF_HI_CTRL, 32'h0, "hi ctrl reset");
      rd_chk(tpc_pkg::OFF_CAP_CTL, 32'h0, "cap ctrl reset");
      rd_chk(tpc_pkg::OFF_LO_PER, 32'h0000ffff, "lo period reset");
      rd_chk(8'h20, 32'h0, "unmapped read");
      check("unmapped error", {31'h0, e}, 32'h1);
      wr(tpc_pkg::OFF_LO_CTRL, 16'hffff);
      rd_chk(tpc_pkg::OFF_LO_CTRL, 32'h0000a07a, "lo ctrl mask");
      wr(tpc_pkg::OFF_HI_CTRL, 16'hffff);
      rd_chk(tpc_pkg::OFF_HI_CTRL, 32'h0000a072, "hi ctrl mask");
      wr(tpc_pkg::OFF_CAP_CTL, 16'hffff);
      rd_chk(tpc_pkg::OFF_CAP_CTL, 32'h000020e7, "cap ctrl mask");
      wr(tpc_pkg::OFF_LO_CTRL, 16'h0000);
      wr(tpc_pkg::OFF_HI_CTRL, 16'h0000);
      wr(tpc_pkg::OFF_CAP_CTL, 16'h0000);
      // prescale ratios from the ticks seen over a fixed run
      for (int ps = 0; ps < 4; ps++)
      begin
         b0 = (ps == 0) ? 1 : (ps == 1) ? 8 : (ps == 2) ? 64 : 256;
         wr(tpc_pkg::OFF_LO_CNT, 16'h0000);
         wr(tpc_pkg::OFF_LO_CTRL, 16'h8000 | 16'(ps << 4));
         repeat (512) @(posedge pclk);
         wr(tpc_pkg::OFF_LO_CTRL, 16'h0000);
         rd_rng(tpc_pkg::OFF_LO_CNT, 512 / b0, 520 / b0 + 1);
      end
      wr(tpc_pkg::OFF_LO_CNT, 16'h0000);
      idle_mode <= 1'b1;
      wr(tpc_pkg::OFF_LO_CTRL, 16'ha000);
      repeat (30) @(posedge pclk);
      rd_chk(tpc_pkg::OFF_LO_CNT, 32'h0, "idle stopped");
      wr(tpc_pkg::OFF_LO_CTRL, 16'h8000);
      repeat (30) @(posedge pclk);
      wr(tpc_pkg::OFF_LO_CTRL, 16'h0000);
      idle_mode <= 1'b0;
      rd_rng(tpc_pkg::OFF_LO_CNT, 30, 40);
      wr(tpc_pkg::OFF_LO_CNT, 16'h0000);
      wr(tpc_pkg::OFF_LO_CTRL, 16'h8040);
      repeat (20) @(posedge pclk);
      rd_chk(tpc_pkg::OFF_LO_CNT, 32'h0, "gate low");
      u_pin_model.drive(1, 1'b1);
      repeat (20) @(posedge pclk);
      u_pin_model.drive(1, 1'b0);
      repeat (4) @(posedge pclk);
      wr(tpc_pkg::OFF_LO_CTRL, 16'h0000);
      rd_rng(tpc_pkg::OFF_LO_CNT, 17, 23);
      // external edges with the gate bit set too, which must not matter
      for (int k = 0; k < 2; k++)
      begin
         b0 = k ? tpc_pkg::OFF_HI_CTRL : tpc_pkg::OFF_LO_CTRL;
         wr(8'(b0 + 8), 16'h0000);
         wr(8'(b0), 16'h8042);
         u_pin_model.pulses(k + 1, 5);
         repeat (4) @(posedge pclk);
         wr(8'(b0), 16'h0000);
         rd_chk(8'(b0 + 8), 32'h5, "ext count");
      end
      wr(tpc_pkg::OFF_LO_CTRL, 16'h0008);
      wr(tpc_pkg::OFF_LO_CNT, 16'hfffe);
      wr(tpc_pkg::OFF_HI_CNT, 16'h0000);
      wr(tpc_pkg::OFF_HI_CTRL, 16'h8000);
      repeat (10) @(posedge pclk);
      rd_chk(tpc_pkg::OFF_HI_CNT, 32'h0, "hi run ignored");
      rd_chk(tpc_pkg::OFF_LO_CNT, 32'h0000fffe, "lo held");
      wr(tpc_pkg::OFF_LO_CTRL, 16'h8008);
      repeat (5) @(posedge pclk);
      wr(tpc_pkg::OFF_LO_CTRL, 16'h0008);
      rd_chk(tpc_pkg::OFF_HI_CNT, 32'h1, "carry to upper");
      wr(tpc_pkg::OFF_LO_PER, 16'h0010);
      wr(tpc_pkg::OFF_HI_PER, 16'h0001);
      wr(tpc_pkg::OFF_LO_CNT, 16'h0000);
      b0 = n_low;
      b1 = n_high;
      wr(tpc_pkg::OFF_LO_CTRL, 16'h8008);
      repeat (40) @(posedge pclk);
      wr(tpc_pkg::OFF_HI_CTRL, 16'h0000);
      wr(tpc_pkg::OFF_LO_CTRL, 16'h0000);
      check("joined match", 32'(n_high - b1), 32'h1);
      check("low irq silent", 32'(n_low - b0), 32'h0);
      wr(tpc_pkg::OFF_LO_CNT, 16'h0000);
      wr(tpc_pkg::OFF_LO_CTRL, 16'h8000);
      repeat (20) @(posedge pclk);
      wr(tpc_pkg::OFF_LO_CTRL, 16'h0000);
      check("low irq", 32'(n_low - b0), 32'h1);
      wr(tpc_pkg::OFF_HI_CNT, 16'h1234);
      wr(tpc_pkg::OFF_CAP_CTL, 16'h0003);
      u_pin_model.pulses(0, 5);
      repeat (8) @(posedge pclk);
      rd_chk(tpc_pkg::OFF_CAP_CTL, 32'h001b, "overrun set");
      repeat (4) rd_chk(tpc_pkg::OFF_CAP_BUF, 32'h1234, "fifo");
      rd_chk(tpc_pkg::OFF_CAP_BUF, 32'h0, "empty read");
      rd_chk(tpc_pkg::OFF_CAP_CTL, 32'h0013, "empty flag");
      wr(tpc_pkg::OFF_CAP_CTL, 16'h0018);
      rd_chk(tpc_pkg::OFF_CAP_CTL, 32'h0, "status read only");
      wr(tpc_pkg::OFF_LO_CNT, 16'h0abc);
      wr(tpc_pkg::OFF_CAP_CTL, 16'h0083);
      u_pin_model.pulses(0, 1);
      repeat (8) @(posedge pclk);
      rd_chk(tpc_pkg::OFF_CAP_BUF, 32'h0abc, "low timebase");
      // mode, rate, idle-halt and wake cases
      for (int i = 0; i < 14; i++)
      begin
         wr(tpc_pkg::OFF_CAP_CTL, 16'h0000);
         idle_mode  <= t_env[i][0];
         sleep_mode <= t_env[i][1];
         wr(tpc_pkg::OFF_CAP_CTL, t_ctl[i]);
         b0 = n_cap;
         b1 = n_wake;
         u_pin_model.pulses(0, t_np[i]);
         repeat (8) @(posedge pclk);
         check("capture irqs", 32'(n_cap - b0), 32'(t_cap[i]));
         check("wake irqs", 32'(n_wake - b1), 32'(t_env[i] / 2 * 2));
         repeat (4) apb(1'b0, tpc_pkg::OFF_CAP_BUF, 32'h0);
         idle_mode  <= 1'b0;
         sleep_mode <= 1'b0;
      end
      end_sim();
   end

   initial
   begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      end_sim();
   end
endmodule
